// *** bench/slc_bus_node.sv ***
// Purpose: RS-485 node on the far side
// Assumes: Bench says when it talks
// Notes: Idle line toggles, never a stale level
`timescale 1ns/1ps
module slc_bus_node (
    // Control
    input wire logic pclk,
    input wire logic talk,
    input wire logic bit_in,
    // Bus
    output logic rxd,
    output logic carrier
);
    initial rxd = 1'b1;
    initial carrier = 1'b0;
    always @(posedge pclk) begin
        carrier <= talk;
        rxd <= talk ? bit_in : ~rxd;
    end
endmodule // slc_bus_node

// *** bench/slc_line_ctrl_properties.sv ***
// Purpose: Port checks for slc_line_ctrl
// Assumes: Config changes only by APB writes
// Notes: Bound at the foot of this file
`timescale 1ns/1ps
module slc_line_ctrl_properties (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Lines
    input wire logic rs232_rxd,
    input wire logic rs232_rts,
    input wire logic rs232_cd,
    input wire logic rs232_cts,
    input wire logic rs485_rxd,
    input wire logic rs485_txd,
    input wire logic rs485_drv_en,
    input wire logic rs485_rx_en
);
    // ====
    // Config shadow
    logic [31:0] cfg_q;
    logic [3:0] age_q;
    logic [15:0] hi_q;
    wire ok = age_q == 4'hf;
    wire lead = cfg_q[0] ? rs232_cd : rs232_rts;
    wire on = cfg_q[9:8] == slc_pkg::CTS_ON;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= slc_pkg::CFG_RST;
            age_q <= 4'h0;
            hi_q <= 16'h0;
        end else begin
            hi_q <= !rs232_rxd ? 16'h0 : hi_q + 16'(hi_q != 16'hffff);
            if (psel && !penable && pwrite && paddr == slc_pkg::CFG_ADDR) begin
                cfg_q <= pwdata & slc_pkg::CFG_MASK;
                age_q <= 4'h0;
            end else if (!ok) begin
                age_q <= age_q + 4'h1;
            end
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_APB_ANSWER: assert property (psel && !penable |=> pready)
        else $error("no pready");
    AST_CTS_DTE: assert property (ok && cfg_q[0] |-> !rs232_cts)
        else $error("cts in DTE");
    AST_CTS_ON: assert property (ok && !cfg_q[0] && on |-> rs232_cts)
        else $error("cts not held");
    AST_CTS_DROP: assert property ((ok && !on && !rs232_rts) [*5] |-> !rs232_cts)
        else $error("cts stuck");
    AST_DRV_ON: assert property (ok && on |-> rs485_drv_en)
        else $error("driver not held");
    AST_DRV_LEAD: assert property ((ok && !cfg_q[3] && !on && $stable(lead)) [*5]
        |-> rs485_drv_en == lead)
        else $error("lead enable");
    AST_TMO_END: assert property (ok && cfg_q[3] && !on && cfg_q[14:12] == slc_pkg::SEL_E
        && hi_q == 16'(slc_pkg::TMO_150_CYC + 8) |-> !rs485_drv_en)
        else $error("timeout late");
    AST_HALF_RX: assert property ((ok && cfg_q[1] && rs485_drv_en) [*2] |-> !rs485_rx_en)
        else $error("rx in half");
    AST_FULL_RX: assert property (ok && !cfg_q[1] |-> rs485_rx_en)
        else $error("rx off in full");
    AST_PASS: assert property ((ok && !cfg_q[1] && $stable(rs232_rxd) && $stable(rs485_rxd)) [*5]
        |-> rs485_txd == (cfg_q[4] ? rs485_rxd : rs232_rxd))
        else $error("bus data");
    COV_CTS: cover property ($rose(rs232_cts));
    COV_TURN: cover property (cfg_q[1] && $fell(rs485_drv_en));
    COV_ERR: cover property (pready && pslverr);
endmodule // slc_line_ctrl_properties
bind slc_line_ctrl slc_line_ctrl_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .rs232_rxd, .rs232_rts, .rs232_cd, .rs232_cts,
    .rs485_rxd, .rs485_txd, .rs485_drv_en, .rs485_rx_en);

// *** bench/slc_line_ctrl_tb_top.sv ***
// Purpose: Self-checking bench for slc_line_ctrl
// Assumes: Short timeout and turnaround selects
// Notes: 10 and 30 ms delays checked for not firing early
`timescale 1ns/1ps
module slc_line_ctrl_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, r, v;
    logic pready, pslverr, e, rs232_txd, rs232_cts, rs485_rxd, rs485_carrier, rs485_txd;
    logic rs232_rxd = 1'b1, rs232_rts = 1'b0, rs232_cd = 1'b0, talk = 1'b0, bit_in = 1'b1;
    logic rs485_drv_en, rs485_rx_en;
    int err_count = 0, tests_run = 0, cyc_n = 0;
    always #25 pclk = ~pclk;
    slc_line_ctrl u_slc_line_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rs232_rxd, .rs232_rts, .rs232_cd, .rs232_txd, .rs232_cts,
        .rs485_rxd, .rs485_carrier, .rs485_txd, .rs485_drv_en, .rs485_rx_en);
    slc_bus_node u_slc_bus_node (.pclk, .talk, .bit_in, .rxd(rs485_rxd), .carrier(rs485_carrier));
    // ====
    // Tasks
    task automatic report_and_stop;
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            err_count++;
            $display("wrong value %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic pin(input string n, input logic x, input logic g);
        chk(n, {31'h0, x}, {31'h0, g});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [1:0] exp_st(logic dte, logic [1:0] s, logic rts, logic cd,
        logic blk);
        logic cts;
        cts = !dte && (s == slc_pkg::CTS_ON || (s == slc_pkg::CTS_0 && rts && !blk));
        return {cts, s == slc_pkg::CTS_ON || (dte ? cd : rts)};
    endfunction
    always @(posedge pclk) begin
        cyc_n++;
        if (cyc_n == 60000) begin
            err_count++;
            report_and_stop();
        end
    end
    // ====
    // Scenarios
    initial begin
        int tm;
        int ta;
        void'($urandom(32'h120ecc40));
        cyc(16);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, slc_pkg::CFG_ADDR, 32'h0);
        chk("cfg rst", slc_pkg::CFG_RST, r);
        v = $urandom & 32'h0007_7335;
        apb(1'b1, slc_pkg::CFG_ADDR, v);
        apb(1'b0, slc_pkg::CFG_ADDR, 32'h0);
        chk("cfg", v & slc_pkg::CFG_MASK, r);
        apb(1'b1, slc_pkg::STAT_ADDR, v);
        pin("ro err", 1'b1, e);
        apb(1'b0, 12'h008, v);
        pin("map err", 1'b1, e);
        for (int i = 0; i < 16; i++) begin
            logic inh, bias, car, cd;
            logic [1:0] x;
            {inh, bias, car, cd} = 4'($urandom);
            bias = bias && !inh;
            @(posedge pclk);
            rs232_rts <= 1'b0;
            talk <= car;
            rs232_cd <= cd;
            apb(1'b1, slc_pkg::CFG_ADDR, {22'h0, i[1:0], 2'h0, bias, 2'h0, inh, 1'b0, i[2]});
            cyc(20);
            @(posedge pclk);
            rs232_rts <= 1'b1;
            cyc(30);
            apb(1'b0, slc_pkg::STAT_ADDR, 32'h0);
            x = exp_st(i[2], i[1:0], 1'b1, cd, inh && car);
            chk("status", {29'h0, car | bias, x},
                r & 32'h7);
            pin("cts", x[1], rs232_cts);
            @(posedge pclk);
            rs232_rts <= 1'b0;
            cyc(8);
            chk("drop", {30'h0, exp_st(i[2], i[1:0], 1'b0, cd, 1'b0)},
                {30'h0, rs232_cts, rs485_drv_en});
        end
        for (int k = 0; k < 8; k++) begin
            logic a, b;
            {a, b} = 2'($urandom);
            apb(1'b1, slc_pkg::CFG_ADDR, {27'h0, k[2], 4'h0});
            @(posedge pclk);
            rs232_rxd <= a;
            talk <= 1'b1;
            bit_in <= b;
            cyc(20);
            pin("txd485", k[2] ? b : a, rs485_txd);
            pin("txd232", k[2] ? a : b, rs232_txd);
        end
        for (int k = 0; k < 2; k++) begin
            tm = k ? slc_pkg::TMO_700_CYC : slc_pkg::TMO_150_CYC;
            ta = k ? 0 : slc_pkg::TA_100_CYC;
            v = {13'h0, k ? slc_pkg::SEL_A : slc_pkg::SEL_B, 1'b0,
                k ? slc_pkg::SEL_D : slc_pkg::SEL_E, 12'h00a};
            apb(1'b1, slc_pkg::CFG_ADDR, v);
            cyc(20);
            @(posedge pclk);
            rs232_rxd <= 1'b0;
            cyc(20);
            pin("drv on", 1'b1, rs485_drv_en);
            repeat (30) begin
                @(posedge pclk);
                rs232_rxd <= 1'($urandom);
                cyc(4);
            end
            @(posedge pclk);
            rs232_rxd <= 1'b0;
            cyc(8);
            @(posedge pclk);
            rs232_rxd <= 1'b1;
            cyc(tm - 10);
            pin("drv held", 1'b1, rs485_drv_en);
            pin("rx off", 1'b0, rs485_rx_en);
            cyc(20);
            pin("drv end", 1'b0, rs485_drv_en);
            if (ta > 0) begin
                cyc(ta - 100);
                pin("turn", 1'b0, rs485_rx_en);
            end
            cyc(150);
            pin("rx back", 1'b1, rs485_rx_en);
        end
        report_and_stop();
    end
endmodule // slc_line_ctrl_tb_top

// *** rtl/slc_line_ctrl.sv ***
// Purpose: Line control of an RS-232 to RS-485 converter
// Assumes: Straps held in a config register written over APB
// Notes: Serial and lead inputs are synchronised before use
//
// Overview of operation
// R1: Role bit high selects DTE, low DCE
// R2: Duplex bit selects two or four wire
// R3: CTS ON with lead source holds driver on
// R4: DCE raises CTS after 0, 10, 30 ms
// R5: Carrier inhibit withholds CTS on busy line
// R6: CTS drops at once when RTS falls
// R7: CTS ON holds CTS asserted always in DCE role
// R8: DTE role gives no CTS
// R9: Lead enables driver only with delay settings
// R10: DTE lead mode: CD enables driver
// R11: DCE lead mode: RTS enables driver
// R12: Data mode: first bit enables, starts timer
// R13: Rising data restarts timer; expiry disables
// R14: Timeouts 0.15, 0.7, 2, 7, 70 ms
// R15: Above 64 kbps host sends lead-in char
// R16: CTS ON keeps driver constantly enabled
// R17: Half duplex waits turnaround before receive
// R18: Turnaround 0, 0.1, 1, 5, 35 ms
// R19: Loopback echoes each port to itself
// R20: Normal mode passes data across
// R21: Line bias reports carrier always present
// R22: DTE with CTS ON ignores CD
// R23: Timers count pclk; straps sampled synchronously
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
module slc_line_ctrl (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB requests
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // APB answers
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // RS-232 inputs
    input wire logic rs232_rxd,
    input wire logic rs232_rts,
    input wire logic rs232_cd,
    // RS-232 outputs
    output logic rs232_txd,
    output logic rs232_cts,
    // RS-485 inputs
    input wire logic rs485_rxd,
    input wire logic rs485_carrier,
    // RS-485 outputs
    output logic rs485_txd,
    output logic rs485_drv_en,
    output logic rs485_rx_en
);

    // ========================================================
    // State
    // CTS sequencer states
    typedef enum {ST_IDLE, ST_WAIT, ST_ON} slc_cts_t;

    typedef struct packed {
        // Register interface
        logic [31:0] cfg;
        logic [31:0] rdata;
        logic ready;
        logic err;

        // Synchronisers
        logic [1:0] rxd_s;
        logic [1:0] rts_s;
        logic [1:0] cd_s;
        logic [1:0] rxr_s;
        logic [1:0] car_s;
        logic rxd_p;
        logic rts_p;

        // CTS sequencing
        slc_cts_t cts_st;
        logic [20:0] cts_cnt;
        logic cts;

        // Driver timer
        logic data_en;
        logic [20:0] tmo_cnt;
        logic drv;

        // Turnaround
        logic ta;
        logic [20:0] ta_cnt;
        logic rx_en;

        // Line outputs
        logic txd232;
        logic txd485;
    } slc_state_t;

    slc_state_t q, d;

    // ========================================================
    // Decode helpers
    function automatic logic rise(input logic now, input logic was);
        rise = now & ~was;
    endfunction

    function automatic logic [20:0] cyc(input int unsigned n);
        cyc = n[20:0];
    endfunction

    function automatic logic [20:0] tmo_len(input logic [2:0] s);
        unique case (s)
            slc_pkg::SEL_A: tmo_len = cyc(slc_pkg::TMO_70_CYC);
            slc_pkg::SEL_B: tmo_len = cyc(slc_pkg::TMO_7_CYC);
            slc_pkg::SEL_C: tmo_len = cyc(slc_pkg::TMO_2_CYC);
            slc_pkg::SEL_D: tmo_len = cyc(slc_pkg::TMO_700_CYC);
            slc_pkg::SEL_E: tmo_len = cyc(slc_pkg::TMO_150_CYC);
            default: tmo_len = cyc(slc_pkg::TMO_150_CYC);
        endcase
    endfunction

    function automatic logic [20:0] ta_len(input logic [2:0] s);
        unique case (s)
            slc_pkg::SEL_A: ta_len = '0;
            slc_pkg::SEL_B: ta_len = cyc(slc_pkg::TA_100_CYC);
            slc_pkg::SEL_C: ta_len = cyc(slc_pkg::TA_1_CYC);
            slc_pkg::SEL_D: ta_len = cyc(slc_pkg::TA_5_CYC);
            slc_pkg::SEL_E: ta_len = cyc(slc_pkg::TA_35_CYC);
            default: ta_len = cyc(slc_pkg::TA_35_CYC);
        endcase
    endfunction

    function automatic logic [20:0] cts_delay_len(input logic [1:0] s);
        unique case (s)
            slc_pkg::CTS_0: cts_delay_len = '0;
            slc_pkg::CTS_10: cts_delay_len = cyc(slc_pkg::CTS_10_CYC);
            slc_pkg::CTS_30: cts_delay_len = cyc(slc_pkg::CTS_30_CYC);
            slc_pkg::CTS_ON: cts_delay_len = '0;
        endcase
    endfunction

    function automatic logic [31:0] stat_word(input logic drv_on, input logic cts_on,
                                              input logic car_on, input logic ta_on);
        stat_word = '0;
        stat_word[slc_pkg::S_DRV] = drv_on;
        stat_word[slc_pkg::S_CTS] = cts_on;
        stat_word[slc_pkg::S_CAR] = car_on;
        stat_word[slc_pkg::S_TA] = ta_on;
    endfunction

    // ========================================================
    // Config fields and derived conditions
    logic role_dte;
    logic duplex_half;
    logic cinh;
    logic src_data;
    logic loop_on;
    logic bias_on;
    logic [1:0] cts_sel;
    logic [2:0] tmo_sel;
    logic [2:0] ta_sel;

    logic car;
    logic lead;
    logic [20:0] cts_len;
    logic setup;
    logic rts_rise;
    logic rxd_rise;
    logic cts_block;
    logic drv_forced;

    assign role_dte = q.cfg[slc_pkg::F_ROLE];
    assign duplex_half = q.cfg[slc_pkg::F_DUPLEX];
    assign cinh = q.cfg[slc_pkg::F_CINH];
    assign src_data = q.cfg[slc_pkg::F_SRC];
    assign loop_on = q.cfg[slc_pkg::F_LOOP];
    assign bias_on = q.cfg[slc_pkg::F_BIAS];
    assign cts_sel = q.cfg[slc_pkg::F_CTS +: 2];
    assign tmo_sel = q.cfg[slc_pkg::F_TMO +: 3];
    assign ta_sel = q.cfg[slc_pkg::F_TA +: 3];
    assign car = q.car_s[1] | bias_on; // R21
    assign cts_len = cts_delay_len(cts_sel); // R4

    assign lead = role_dte ? q.cd_s[1] : q.rts_s[1]; // R10 R11
    assign setup = psel & ~penable;
    assign rts_rise = rise(q.rts_s[1], q.rts_p);
    assign rxd_rise = rise(q.rxd_s[1], q.rxd_p);
    assign cts_block = cinh & car; // R5
    assign drv_forced = cts_sel == slc_pkg::CTS_ON; // R3 R16 R22

    // ========================================================
    // Next state
    always_comb begin
        d = q;

        // ========================================================
        // Synchronisers
        d.rxd_s = {q.rxd_s[0], rs232_rxd}; // R23
        d.rts_s = {q.rts_s[0], rs232_rts};
        d.cd_s = {q.cd_s[0], rs232_cd};
        d.rxr_s = {q.rxr_s[0], rs485_rxd};
        d.car_s = {q.car_s[0], rs485_carrier};
        d.rxd_p = q.rxd_s[1];
        d.rts_p = q.rts_s[1];

        // ========================================================
        // APB slave, one wait-free access phase
        d.ready = setup;
        d.err = 1'b0;
        d.rdata = '0;

        if (setup) begin
            unique case (paddr)
                slc_pkg::CFG_ADDR: begin
                    d.rdata = q.cfg;
                    if (pwrite) begin
                        d.cfg = pwdata & slc_pkg::CFG_MASK; // R23
                    end
                end
                slc_pkg::STAT_ADDR: begin
                    d.rdata = stat_word(q.drv, q.cts, car, q.ta);
                    d.err = pwrite;
                end
                default: d.err = 1'b1;
            endcase
        end

        // ========================================================
        // CTS sequencing, DCE only
        unique case (q.cts_st)
            ST_IDLE: begin
                if (rts_rise && !cts_block) begin // R5
                    d.cts_st = ST_WAIT;
                    d.cts_cnt = cts_len;
                end
            end
            ST_WAIT: begin
                if (q.cts_cnt == '0) begin
                    d.cts_st = ST_ON;
                end else begin
                    d.cts_cnt = q.cts_cnt - 21'h1;
                end
            end
            ST_ON: ;
        endcase

        if (!q.rts_s[1]) begin
            d.cts_st = ST_IDLE; // R6
        end

        // ========================================================
        // CTS output
        if (role_dte) begin
            d.cts = 1'b0; // R8
        end else if (cts_sel == slc_pkg::CTS_ON) begin
            d.cts = 1'b1; // R7
        end else begin
            d.cts = (d.cts_st == ST_ON) && q.rts_s[1]; // R4 R6
        end

        // ========================================================
        // Data enabled driver timer
        if (rxd_rise) begin
            d.tmo_cnt = tmo_len(tmo_sel); // R13 R14
        end else if (q.tmo_cnt != '0) begin
            d.tmo_cnt = q.tmo_cnt - 21'h1;
        end

        // ========================================================
        // Data enable flag
        if (!q.rxd_s[1]) begin
            d.data_en = 1'b1; // R12
        end else if (q.rxd_p && q.tmo_cnt == 21'h1) begin
            d.data_en = 1'b0; // R13
        end

        // ========================================================
        // Driver enable source
        if (drv_forced) begin
            d.drv = 1'b1; // R3 R16 R22
        end else if (src_data) begin
            d.drv = d.data_en; // R12
        end else begin
            d.drv = lead; // R9
        end

        // ========================================================
        // Half duplex turnaround
        if (!duplex_half) begin
            d.rx_en = 1'b1; // R2
            d.ta = 1'b0;
        end else if (d.drv) begin
            d.rx_en = 1'b0;
            d.ta = 1'b0;
        end else if (q.drv) begin
            d.ta = 1'b1; // R17
            d.ta_cnt = ta_len(ta_sel); // R18
            d.rx_en = 1'b0;
        end else if (q.ta) begin
            if (q.ta_cnt == '0) begin
                d.ta = 1'b0;
                d.rx_en = 1'b1;
            end else begin
                d.ta_cnt = q.ta_cnt - 21'h1;
            end
        end else begin
            d.rx_en = 1'b1;
        end

        // ========================================================
        // Data paths
        if (loop_on) begin
            d.txd232 = q.rxd_s[1]; // R19
            d.txd485 = q.rxr_s[1];
        end else begin
            d.txd232 = (duplex_half && !q.rx_en) ? 1'b1 : q.rxr_s[1]; // R20
            d.txd485 = q.rxd_s[1];
        end
    end

    // ========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{
                cfg: slc_pkg::CFG_RST,
                rdata: '0,
                ready: 1'b0,
                err: 1'b0,
                rxd_s: 2'h3,
                rts_s: 2'h0,
                cd_s: 2'h0,
                rxr_s: 2'h3,
                car_s: 2'h0,
                rxd_p: 1'b1,
                rts_p: 1'b0,
                cts_st: ST_IDLE,
                cts_cnt: '0,
                cts: 1'b0,
                data_en: 1'b0,
                tmo_cnt: '0,
                drv: 1'b0,
                ta: 1'b0,
                ta_cnt: '0,
                rx_en: 1'b1,
                txd232: 1'b1,
                txd485: 1'b1
            };
        end else begin
            q <= d;
        end
    end

    // ========================================================
    // Outputs
    // APB answers
    assign prdata = q.rdata;
    assign pready = q.ready;
    assign pslverr = q.err;

    // RS-232 lines
    assign rs232_txd = q.txd232;
    assign rs232_cts = q.cts;

    // RS-485 lines
    assign rs485_txd = q.txd485;
    assign rs485_drv_en = q.drv;
    assign rs485_rx_en = q.rx_en;

endmodule // slc_line_ctrl

// *** rtl/slc_pkg.sv ***
// Purpose: Shared constants for the serial line control block
// Assumes: pclk at 20 MHz
// Notes: Register map, strap encodings and timer counts
package slc_pkg;
    // ========================================================
    // Clock and times
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned US_CYC = CLK_HZ / 1000000;
    localparam int unsigned CTS_10_US = 10000;
    localparam int unsigned CTS_30_US = 30000;
    localparam int unsigned TMO_150_US = 150;
    localparam int unsigned TMO_700_US = 700;
    localparam int unsigned TMO_2_US = 2000;
    localparam int unsigned TMO_7_US = 7000;
    localparam int unsigned TMO_70_US = 70000;
    localparam int unsigned TA_100_US = 100;
    localparam int unsigned TA_1_US = 1000;
    localparam int unsigned TA_5_US = 5000;
    localparam int unsigned TA_35_US = 35000;
    localparam int unsigned CTS_10_CYC = CTS_10_US * US_CYC;
    localparam int unsigned CTS_30_CYC = CTS_30_US * US_CYC;
    localparam int unsigned TMO_150_CYC = TMO_150_US * US_CYC;
    localparam int unsigned TMO_700_CYC = TMO_700_US * US_CYC;
    localparam int unsigned TMO_2_CYC = TMO_2_US * US_CYC;
    localparam int unsigned TMO_7_CYC = TMO_7_US * US_CYC;
    localparam int unsigned TMO_70_CYC = TMO_70_US * US_CYC;
    localparam int unsigned TA_100_CYC = TA_100_US * US_CYC;
    localparam int unsigned TA_1_CYC = TA_1_US * US_CYC;
    localparam int unsigned TA_5_CYC = TA_5_US * US_CYC;
    localparam int unsigned TA_35_CYC = TA_35_US * US_CYC;
    localparam int unsigned CNT_W = 21;
    // ========================================================
    // Register byte addresses
    localparam logic [11:0] CFG_ADDR = 12'h000;
    localparam logic [11:0] STAT_ADDR = 12'h004;
    // ========================================================
    // Config field positions
    localparam int unsigned F_ROLE = 0;
    localparam int unsigned F_DUPLEX = 1;
    localparam int unsigned F_CINH = 2;
    localparam int unsigned F_SRC = 3;
    localparam int unsigned F_LOOP = 4;
    localparam int unsigned F_BIAS = 5;
    localparam int unsigned F_CTS = 8;
    localparam int unsigned F_TMO = 12;
    localparam int unsigned F_TA = 16;
    localparam logic [31:0] CFG_MASK = 32'h0007_733f;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    // ========================================================
    // Encodings
    localparam logic [1:0] CTS_0 = 2'h0;
    localparam logic [1:0] CTS_10 = 2'h1;
    localparam logic [1:0] CTS_30 = 2'h2;
    localparam logic [1:0] CTS_ON = 2'h3;
    localparam logic [2:0] SEL_A = 3'h0;
    localparam logic [2:0] SEL_B = 3'h1;
    localparam logic [2:0] SEL_C = 3'h2;
    localparam logic [2:0] SEL_D = 3'h3;
    localparam logic [2:0] SEL_E = 3'h4;
    // Status bit positions
    localparam int unsigned S_DRV = 0;
    localparam int unsigned S_CTS = 1;
    localparam int unsigned S_CAR = 2;
    localparam int unsigned S_TA = 3;
endpackage
